// file: shared/cicd_map.svh
// Constants of the instruction class decoder: sizes, masks, fields and encodings.
`ifndef CICD_MAP_SVH
`define CICD_MAP_SVH

// -----------------------------------------------------------------------------
// Instruction set
// -----------------------------------------------------------------------------
`define CICD_OP_COUNT      7'h41
`define CICD_NREGS         8
`define CICD_SP_IDX        3'h7
`define CICD_ONE_REG       8'h01
`define CICD_MIN_LIST      2
`define CICD_TAS_REG_MASK  8'h33

// -----------------------------------------------------------------------------
// Allowed-size masks, one bit per size code (byte, word, long, none)
// -----------------------------------------------------------------------------
`define CICD_SZ_B          4'h1
`define CICD_SZ_BW         4'h3
`define CICD_SZ_WL         4'h6
`define CICD_SZ_L          4'h4
`define CICD_SZ_BWL        4'h7
`define CICD_SZ_NONE       4'h8

// -----------------------------------------------------------------------------
// Stack steps and address alignment
// -----------------------------------------------------------------------------
`define CICD_BYTES_WORD    32'h0000_0002
`define CICD_BYTES_LONG    32'h0000_0004
`define CICD_ALIGN_MASK    24'hFF_FFFE

// -----------------------------------------------------------------------------
// Fault vector bit positions
// -----------------------------------------------------------------------------
`define CICD_F_UNKNOWN     0
`define CICD_F_SIZE        1
`define CICD_F_PSYNC       2
`define CICD_F_SP_LIST     3
`define CICD_F_LIST_SHORT  4
`define CICD_F_TAS_REG     5

// -----------------------------------------------------------------------------
// Field lengths and register-file lanes
// -----------------------------------------------------------------------------
`define CICD_IMM8          6'h08
`define CICD_IMM16         6'h10
`define CICD_IMM24         6'h18
`define CICD_IMM32         6'h20
`define CICD_LANES_ALL     4'hF
`define CICD_LANES_LO16    4'h3
`define CICD_LANES_HI16    4'hC
`define CICD_LANES_B0      4'h1
`define CICD_LANES_B1      4'h2
`define CICD_SHIFT_NONE    5'h00
`define CICD_SHIFT_BYTE    5'h08
`define CICD_SHIFT_HALF    5'h10

`endif

// file: shared/cicd_pkg.sv
// Types of the instruction class decoder.
package cicd_pkg;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_NONE} cicd_size_t;

	typedef enum logic [2:0] {EA_REG, EA_IMM, EA_MEM, EA_STK_POP, EA_STK_PUSH} cicd_mode_t;

	typedef enum logic [2:0] {
		CL_TRANSFER, CL_ARITH, CL_LOGIC, CL_SHIFT, CL_BIT, CL_BRANCH, CL_SYSTEM, CL_BLOCK
	} cicd_class_t;

	typedef enum logic [6:0] {
		OP_GEN_XFER, OP_STK_LD_MULTI, OP_STK_ST_MULTI, OP_PSYNC_RD, OP_PSYNC_WR,
		OP_ADD, OP_SUB, OP_CMP, OP_NEG, OP_ADD_CARRY, OP_SUB_BORROW, OP_DEC_ADJ_ADD,
		OP_DEC_ADJ_SUB, OP_INCR, OP_DECR, OP_QADD_CONST, OP_QSUB_CONST, OP_UMUL, OP_UDIV,
		OP_SMUL, OP_SDIV, OP_ZERO_EXT, OP_SIGN_EXT, OP_TEST_SET,
		OP_AND, OP_OR, OP_XOR, OP_NOT,
		OP_ASHL, OP_ASHR, OP_LSHL, OP_LSHR, OP_ROL, OP_ROR, OP_ROLC, OP_RORC,
		OP_BIT_SET, OP_BIT_CLR, OP_BIT_INV, OP_BIT_TST, OP_BIT_LD, OP_BIT_ILD, OP_BIT_ST,
		OP_BIT_IST, OP_BIT_AND, OP_BIT_IAND, OP_BIT_OR, OP_BIT_IOR, OP_BIT_XOR, OP_BIT_IXOR,
		OP_BR_COND, OP_JUMP, OP_BR_SUB, OP_JUMP_SUB, OP_RET_SUB,
		OP_TRAP, OP_EXC_RET, OP_SLEEP, OP_CTL_LD, OP_CTL_ST, OP_CTL_AND, OP_CTL_OR,
		OP_CTL_XOR, OP_NOP,
		OP_BLK_COPY
	} cicd_op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_MEM, ST_REPORT} cicd_state_t;

	typedef struct packed {
		logic [6:0]  op;
		cicd_size_t  size;
		cicd_mode_t  mode;
		logic [3:0]  reg_spec;
		logic [7:0]  reg_list;
		logic [1:0]  imm_code;
		logic [23:0] pc;
	} cicd_ins_t;

	typedef struct packed {
		cicd_op_t    op;
		cicd_class_t cls;
		cicd_size_t  size;
		logic [5:0]  fault;
		logic [5:0]  imm_bits;
		logic [23:0] fetch_addr;
	} cicd_dec_t;

	typedef struct packed {
		logic        we;
		cicd_size_t  size;
		logic [23:0] addr;
		logic [31:0] wdata;
	} cicd_mem_t;

endpackage

// file: src/cicd_reg_view.sv
// Overlaid byte, half and long views of one general register.
`timescale 1ns/1ps
`default_nettype none
`include "cicd_map.svh"

module cicd_reg_view
	import cicd_pkg::*;
(
	input  wire cicd_size_t  size,
	input  wire logic [3:0]  spec,
	input  wire logic [31:0] rf_word,
	input  wire logic [31:0] field_in,
	output logic      [2:0]  er_idx,
	output logic      [3:0]  lanes,
	output logic      [31:0] field,
	output logic      [31:0] word_out
);

	// -------------------------------------------------------------------------
	// Decode of the register specifier
	// -------------------------------------------------------------------------
	// Byte: bit 3 picks low byte, else high byte. Half: bit 3 picks the extended half.
	logic [4:0]  shift;
	logic [31:0] keep;

	assign er_idx = spec[2:0];
	assign lanes  = (size == SZ_BYTE) ? (spec[3] ? `CICD_LANES_B0 : `CICD_LANES_B1) :
			(size == SZ_WORD) ? (spec[3] ? `CICD_LANES_HI16 : `CICD_LANES_LO16) :
			`CICD_LANES_ALL;
	assign shift  = (size == SZ_BYTE) ? (spec[3] ? `CICD_SHIFT_NONE : `CICD_SHIFT_BYTE) :
			(size == SZ_WORD) ? (spec[3] ? `CICD_SHIFT_HALF : `CICD_SHIFT_NONE) :
			`CICD_SHIFT_NONE;
	assign keep   = (size == SZ_BYTE) ? 32'h0000_00FF :
			(size == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;

	// -------------------------------------------------------------------------
	// Extraction and insertion
	// -------------------------------------------------------------------------
	assign field    = (rf_word >> shift) & keep;
	assign word_out = (field_in & keep) << shift;

endmodule // cicd_reg_view

`default_nettype wire

// file: src/cicd_decoder.sv
// Instruction class decoder with stack transfer sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "cicd_map.svh"

// -----------------------------------------------------------------------------
// Summary of operation
// - Recognise exactly sixty-five instruction types.
// - General transfer allows byte, word, longword.
// - Single pop: word/long, post-increment from stack.
// - Single push: word/long, pre-decrement onto stack.
// - Multiple pop: longword only, post-increment.
// - Multiple push: longword only, pre-decrement.
// - Stack pointer never in register list.
// - Carry, decimal, quick, multiply, extend size limits.
// - Eight shift operations, all three sizes.
// - Fourteen bit operations, byte size only.
// - Nine system control operations.
// - Five branch types.
// - Register file has byte, half, long views.
// - Field lengths of 8, 16, 24, 32 bits.
// - Word/long addresses force bit zero low.
// -----------------------------------------------------------------------------

module cicd_decoder
	import cicd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ins_valid,
	output logic             ins_ready,
	input  wire cicd_ins_t   ins,
	output logic             dec_valid,
	input  wire logic        dec_ready,
	output cicd_dec_t        dec,
	output logic      [2:0]  rf_rd_idx,
	input  wire logic [31:0] rf_rd_data,
	output logic             rf_wr_en,
	output logic      [2:0]  rf_wr_idx,
	output logic      [3:0]  rf_wr_lanes,
	output logic      [31:0] rf_wr_data,
	input  wire logic [31:0] sp_value,
	output logic             sp_wr_en,
	output logic      [31:0] sp_wr_data,
	output logic             mem_req,
	output cicd_mem_t        mem,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack
);

	// -------------------------------------------------------------------------
	// Decode functions
	// -------------------------------------------------------------------------
	function automatic cicd_class_t class_of(input cicd_op_t op);
		cicd_class_t c;
		c = CL_BLOCK;
		if (op <= OP_PSYNC_WR) c = CL_TRANSFER;
		else if (op <= OP_TEST_SET) c = CL_ARITH;
		else if (op <= OP_NOT) c = CL_LOGIC;
		else if (op <= OP_RORC) c = CL_SHIFT;
		else if (op <= OP_BIT_IXOR) c = CL_BIT;
		else if (op <= OP_RET_SUB) c = CL_BRANCH;
		else if (op <= OP_NOP) c = CL_SYSTEM;
		return c;
	endfunction

	function automatic logic [3:0] sizes_of(input cicd_op_t op);
		logic [3:0] m;
		case (op)
			OP_STK_LD_MULTI, OP_STK_ST_MULTI: m = `CICD_SZ_L;
			OP_QADD_CONST, OP_QSUB_CONST: m = `CICD_SZ_L;
			OP_ADD_CARRY, OP_SUB_BORROW, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB: m = `CICD_SZ_B;
			OP_PSYNC_RD, OP_PSYNC_WR, OP_TEST_SET: m = `CICD_SZ_B;
			OP_UMUL, OP_UDIV, OP_SMUL, OP_SDIV: m = `CICD_SZ_BW;
			OP_ZERO_EXT, OP_SIGN_EXT: m = `CICD_SZ_WL;
			default: m = `CICD_SZ_BWL;
		endcase
		if (class_of(op) == CL_BIT) m = `CICD_SZ_B;
		if (class_of(op) inside {CL_BRANCH, CL_SYSTEM, CL_BLOCK}) m = `CICD_SZ_NONE;
		return m;
	endfunction

	// Ascending picks the lowest set bit, descending the highest.
	function automatic logic [2:0] pick_reg(input logic [7:0] set, input logic down);
		logic [2:0] idx;
		idx = '0;
		for (int i = 0; i < `CICD_NREGS; i++) begin
			if (set[i] && down) idx = 3'(i);
			if (set[`CICD_NREGS - 1 - i] && !down) idx = 3'(`CICD_NREGS - 1 - i);
		end
		return idx;
	endfunction

	// -------------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------------
	cicd_state_t state_r, state_nxt;
	cicd_ins_t   ins_r, ins_nxt;
	cicd_dec_t   dec_r, dec_nxt;
	cicd_mem_t   mem_r, mem_nxt;
	logic [7:0]  rem_r, rem_nxt;
	logic [2:0]  cur_r, cur_nxt;
	logic [31:0] sp_work_r, sp_work_nxt;
	logic        mem_req_r, mem_req_nxt;
	logic        wr_en_r, wr_en_nxt;
	logic [2:0]  wr_idx_r, wr_idx_nxt;
	logic [3:0]  wr_lanes_r, wr_lanes_nxt;
	logic [31:0] wr_data_r, wr_data_nxt;
	logic        sp_wr_en_r, sp_wr_en_nxt;
	logic [31:0] sp_wr_data_r, sp_wr_data_nxt;

	// -------------------------------------------------------------------------
	// Instruction decode
	// -------------------------------------------------------------------------
	logic        in_range_w;
	cicd_op_t    op_w;
	logic        stk_mode_w;
	logic        single_w;
	logic        multi_w;
	logic [3:0]  allowed_w;
	logic [5:0]  fault_w;
	logic        start_stk_w;
	logic [7:0]  tas_ok_w;
	logic [5:0]  imm_bits_w;
	cicd_dec_t   dec_w;

	assign in_range_w  = ins.op < `CICD_OP_COUNT;
	assign op_w        = in_range_w ? cicd_op_t'(ins.op) : OP_NOP;
	assign stk_mode_w  = ins.mode inside {EA_STK_POP, EA_STK_PUSH};
	assign single_w    = (op_w == OP_GEN_XFER) && stk_mode_w;
	assign multi_w     = op_w inside {OP_STK_LD_MULTI, OP_STK_ST_MULTI};
	// Stack-pointer accesses refuse byte size, keeping the stack word aligned.
	assign allowed_w   = single_w ? `CICD_SZ_WL : sizes_of(op_w);
	assign tas_ok_w    = `CICD_TAS_REG_MASK;

	assign fault_w[`CICD_F_UNKNOWN]    = !in_range_w;
	assign fault_w[`CICD_F_SIZE]       = in_range_w && !allowed_w[ins.size];
	assign fault_w[`CICD_F_PSYNC]      = op_w inside {OP_PSYNC_RD, OP_PSYNC_WR};
	assign fault_w[`CICD_F_SP_LIST]    = multi_w && ins.reg_list[`CICD_SP_IDX];
	assign fault_w[`CICD_F_LIST_SHORT] = multi_w && ($countones(ins.reg_list) < `CICD_MIN_LIST);
	assign fault_w[`CICD_F_TAS_REG]    = (op_w == OP_TEST_SET) && !tas_ok_w[ins.reg_spec[2:0]];

	assign start_stk_w = (single_w || multi_w) && (fault_w == '0);

	assign imm_bits_w  = (ins.imm_code == 2'h0) ? `CICD_IMM8 :
			(ins.imm_code == 2'h1) ? `CICD_IMM16 :
			(ins.imm_code == 2'h2) ? `CICD_IMM24 : `CICD_IMM32;

	assign dec_w.op         = op_w;
	assign dec_w.cls        = class_of(op_w);
	assign dec_w.size       = ins.size;
	assign dec_w.fault      = fault_w;
	assign dec_w.imm_bits   = imm_bits_w;
	assign dec_w.fetch_addr = ins.pc & `CICD_ALIGN_MASK;

	// -------------------------------------------------------------------------
	// Register views and stack step
	// -------------------------------------------------------------------------
	logic        idle_w;
	cicd_size_t  view_size_w;
	logic [3:0]  view_spec_w;
	logic [2:0]  view_idx_w;
	logic [3:0]  view_lanes_w;
	logic [31:0] view_field_w;
	logic [31:0] view_word_w;
	logic        load_w;
	logic        multi_r_w;
	logic [31:0] step_w;
	logic [31:0] addr_full_w;

	assign idle_w      = state_r == ST_IDLE;
	assign view_size_w = idle_w ? ins.size : ins_r.size;
	assign view_spec_w = idle_w ? ins.reg_spec : ins_r.reg_spec;

	cicd_reg_view cicd_reg_view_i (
		.size     (view_size_w),
		.spec     (view_spec_w),
		.rf_word  (rf_rd_data),
		.field_in (mem_rdata),
		.er_idx   (view_idx_w),
		.lanes    (view_lanes_w),
		.field    (view_field_w),
		.word_out (view_word_w)
	);

	assign multi_r_w   = ins_r.op inside {OP_STK_LD_MULTI, OP_STK_ST_MULTI};
	assign load_w      = (ins_r.op == OP_STK_LD_MULTI) ||
			((ins_r.op == OP_GEN_XFER) && (ins_r.mode == EA_STK_POP));
	assign step_w      = (ins_r.size == SZ_WORD) ? `CICD_BYTES_WORD : `CICD_BYTES_LONG;
	assign addr_full_w = load_w ? sp_work_r : sp_work_r - step_w;

	// -------------------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------------------
	always_comb begin
		state_nxt      = state_r;
		ins_nxt        = ins_r;
		dec_nxt        = dec_r;
		mem_nxt        = mem_r;
		rem_nxt        = rem_r;
		cur_nxt        = cur_r;
		sp_work_nxt    = sp_work_r;
		mem_req_nxt    = mem_req_r;
		wr_en_nxt      = 1'b0;
		wr_idx_nxt     = wr_idx_r;
		wr_lanes_nxt   = wr_lanes_r;
		wr_data_nxt    = wr_data_r;
		sp_wr_en_nxt   = 1'b0;
		sp_wr_data_nxt = sp_wr_data_r;
		unique case (state_r)
			ST_IDLE: begin
				if (ins_valid) begin
					ins_nxt     = ins;
					dec_nxt     = dec_w;
					sp_work_nxt = sp_value;
					rem_nxt     = multi_w ? ins.reg_list : (`CICD_ONE_REG << view_idx_w);
					cur_nxt     = pick_reg(rem_nxt, op_w == OP_STK_LD_MULTI);
					state_nxt   = start_stk_w ? ST_PREP : ST_REPORT;
				end
			end
			ST_PREP: begin
				mem_nxt.we    = !load_w;
				mem_nxt.size  = ins_r.size;
				mem_nxt.addr  = addr_full_w[23:0] & `CICD_ALIGN_MASK;
				mem_nxt.wdata = multi_r_w ? rf_rd_data : view_field_w;
				mem_req_nxt   = 1'b1;
				state_nxt     = ST_MEM;
			end
			ST_MEM: begin
				if (mem_ack) begin
					mem_req_nxt    = 1'b0;
					sp_wr_en_nxt   = 1'b1;
					sp_work_nxt    = load_w ? sp_work_r + step_w : addr_full_w;
					sp_wr_data_nxt = sp_work_nxt;
					if (load_w) begin
						wr_en_nxt    = 1'b1;
						wr_idx_nxt   = cur_r;
						wr_lanes_nxt = multi_r_w ? `CICD_LANES_ALL : view_lanes_w;
						wr_data_nxt  = multi_r_w ? mem_rdata : view_word_w;
					end
					rem_nxt   = rem_r & ~(`CICD_ONE_REG << cur_r);
					cur_nxt   = pick_reg(rem_nxt, load_w);
					state_nxt = (rem_nxt == '0) ? ST_REPORT : ST_PREP;
				end
			end
			ST_REPORT: begin
				if (dec_ready) state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r      <= ST_IDLE;
			ins_r        <= '0;
			dec_r        <= '0;
			mem_r        <= '0;
			rem_r        <= '0;
			cur_r        <= '0;
			sp_work_r    <= '0;
			mem_req_r    <= 1'b0;
			wr_en_r      <= 1'b0;
			wr_idx_r     <= '0;
			wr_lanes_r   <= '0;
			wr_data_r    <= '0;
			sp_wr_en_r   <= 1'b0;
			sp_wr_data_r <= '0;
		end else begin
			state_r      <= state_nxt;
			ins_r        <= ins_nxt;
			dec_r        <= dec_nxt;
			mem_r        <= mem_nxt;
			rem_r        <= rem_nxt;
			cur_r        <= cur_nxt;
			sp_work_r    <= sp_work_nxt;
			mem_req_r    <= mem_req_nxt;
			wr_en_r      <= wr_en_nxt;
			wr_idx_r     <= wr_idx_nxt;
			wr_lanes_r   <= wr_lanes_nxt;
			wr_data_r    <= wr_data_nxt;
			sp_wr_en_r   <= sp_wr_en_nxt;
			sp_wr_data_r <= sp_wr_data_nxt;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	assign ins_ready   = idle_w;
	assign dec_valid   = state_r == ST_REPORT;
	assign dec         = dec_r;
	assign rf_rd_idx   = cur_r;
	assign rf_wr_en    = wr_en_r;
	assign rf_wr_idx   = wr_idx_r;
	assign rf_wr_lanes = wr_lanes_r;
	assign rf_wr_data  = wr_data_r;
	assign sp_wr_en    = sp_wr_en_r;
	assign sp_wr_data  = sp_wr_data_r;
	assign mem_req     = mem_req_r;
	assign mem         = mem_r;

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Order helper: last register moved in the current multiple transfer.
	logic [2:0] last_cur_r;
	logic       seen_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			last_cur_r <= '0;
			seen_r     <= 1'b0;
		end else if (idle_w) begin
			seen_r <= 1'b0;
		end else if ((state_r == ST_MEM) && mem_ack) begin
			last_cur_r <= cur_r;
			seen_r     <= 1'b1;
		end
	end

	sequence seq_pop_done;
		(state_r == ST_MEM) && mem_ack && load_w && !multi_r_w;
	endsequence

	sequence seq_push_prep;
		(state_r == ST_PREP) && !load_w && !multi_r_w;
	endsequence

	AST_TYPE_COUNT: assert property (
		dec_valid |-> (dec.fault[`CICD_F_UNKNOWN] == (ins_r.op >= `CICD_OP_COUNT)))
		else $error("unknown-type fault does not match the opcode range");

	AST_ADDR_ALIGN: assert property (
		mem_req |-> ((mem.addr & ~`CICD_ALIGN_MASK) == '0) && !dec.fetch_addr[0])
		else $error("word or long address has bit zero set");

	AST_POP_STEP: assert property (
		seq_pop_done |=> sp_wr_en && rf_wr_en && (rf_wr_idx == $past(cur_r))
			&& (sp_wr_data == $past(sp_work_r) + $past(step_w)))
		else $error("pop did not post-increment the stack pointer");

	AST_PUSH_PREDEC: assert property (
		seq_push_prep |=> mem_req && mem.we
			&& (mem.addr == (24'($past(sp_work_r) - $past(step_w)) & `CICD_ALIGN_MASK)))
		else $error("push did not pre-decrement the stack pointer");

	AST_MULTI_LONG: assert property (
		mem_req && multi_r_w |-> (mem.size == SZ_LONG) && (rf_rd_idx != `CICD_SP_IDX))
		else $error("multiple transfer not longword or names the stack pointer");

	AST_LIST_NO_SP: assert property (
		(state_r == ST_IDLE) && ins_valid && multi_w && ins.reg_list[`CICD_SP_IDX]
			|=> (state_r == ST_REPORT) && !mem_req)
		else $error("register list with the stack pointer was not refused");

	AST_MULTI_ORDER: assert property (
		(state_r == ST_PREP) && multi_r_w && seen_r
			|-> (load_w ? (cur_r < last_cur_r) : (cur_r > last_cur_r)))
		else $error("multiple transfer visited registers out of order");

	AST_SIZE_LIMIT: assert property (
		dec_valid && (dec.op inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_DEC_ADJ_ADD})
			|-> (dec.fault[`CICD_F_SIZE] == (dec.size != SZ_BYTE)))
		else $error("byte-only operation size check is wrong");

	AST_IMM_LEN: assert property (
		(state_r == ST_IDLE) && ins_valid
			|=> (dec.imm_bits == {3'($past(ins.imm_code)) + 3'h1, 3'h0}))
		else $error("field length does not follow its code");

	AST_BIT_BYTE: assert property (
		dec_valid && (dec.cls == CL_BIT) |-> (dec.fault[`CICD_F_SIZE] == (dec.size != SZ_BYTE)))
		else $error("bit operation accepted a size other than byte");

endmodule // cicd_decoder

`default_nettype wire

// file: testbench/cicd_mem_model.sv
// Data memory partner that answers the decoder's stack port.
`timescale 1ns/1ps
`default_nettype none

module cicd_mem_model
	import cicd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire cicd_mem_t   mem,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack
);
	logic [31:0] ram [64];
	logic [1:0]  wait_r;

	// Between answers the read bus toggles so that stale data is never mistaken for valid.
	always_ff @(posedge core_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!rst_n) begin
			wait_r <= 2'h0;
			mem_rdata <= 32'h0;
		end else if (mem_req && !mem_ack) begin
			wait_r <= wait_r + 2'h1;
			if (!slow || wait_r == 2'h2) begin
				wait_r <= 2'h0;
				mem_ack <= 1'b1;
				mem_rdata <= ram[mem.addr[7:2]];
				if (mem.we)
					ram[mem.addr[7:2]] <= mem.wdata;
			end
		end
	end
endmodule // cicd_mem_model

`default_nettype wire

// file: testbench/cpu_instruction_class_decoder_tb.sv
// Self-checking bench of the instruction class decoder.
`timescale 1ns/1ps
`default_nettype none

module cpu_instruction_class_decoder_tb;
	import cicd_pkg::*;

	logic core_clk, rst_n, ins_valid, ins_ready, dec_valid, dec_ready, slow;
	logic rf_wr_en, sp_wr_en, mem_req, mem_ack;
	logic [2:0] rf_rd_idx, rf_wr_idx;
	logic [3:0] rf_wr_lanes;
	logic [31:0] rf_rd_data, rf_wr_data, sp_value, sp_wr_data, mem_rdata;
	logic [31:0] rf [8];
	logic [23:0] log_a [$];
	cicd_ins_t ins;
	cicd_dec_t dec, got;
	cicd_mem_t mem;
	int n_errors, n_checks, cyc;

	cicd_decoder cicd_decoder_i (.core_clk, .rst_n, .ins_valid, .ins_ready, .ins,
		.dec_valid, .dec_ready, .dec, .rf_rd_idx, .rf_rd_data, .rf_wr_en, .rf_wr_idx,
		.rf_wr_lanes, .rf_wr_data, .sp_value, .sp_wr_en, .sp_wr_data, .mem_req, .mem,
		.mem_rdata, .mem_ack);
	cicd_mem_model cicd_mem_model_i (.core_clk, .rst_n, .slow, .mem_req, .mem,
		.mem_rdata, .mem_ack);

	assign rf_rd_data = rf[rf_rd_idx];

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (mem_req && mem_ack)
			log_a.push_back(mem.addr);
		if (sp_wr_en)
			sp_value <= sp_wr_data;
		if (rf_wr_en)
			for (int b = 0; b < 4; b++)
				if (rf_wr_lanes[b])
					rf[rf_wr_idx][8*b+:8] <= rf_wr_data[8*b+:8];
		if (cyc == 3000) begin
			n_errors++;
			test_done;
		end
	end

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (e !== g) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// -------------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------------
	task automatic run(input logic [6:0] op, input cicd_size_t sz, input cicd_mode_t md,
		input logic [3:0] sp, input logic [7:0] ls, input logic [1:0] im);
		int n;
		log_a.delete();
		ins = '{op, sz, md, sp, ls, im, 24'h00_1235};
		while (ins_ready !== 1'b1)
			@(negedge core_clk);
		ins_valid = 1'b1;
		@(negedge core_clk);
		ins_valid = 1'b0;
		n = 0;
		while (dec_valid !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk("dec_valid", 1, dec_valid);
		got = dec;
		dec_ready = 1'b1;
		@(negedge core_clk);
		dec_ready = 1'b0;
		@(negedge core_clk);
	endtask

	task automatic flt(input logic [6:0] op, input cicd_size_t sz, input cicd_mode_t md,
		input logic [7:0] ls, input logic [3:0] sp, input int b);
		run(op, sz, md, sp, ls, 2'h0);
		chk("fault", 32'(6'h01 << b), 32'(got.fault));
		chk("accesses", 0, log_a.size());
	endtask

	task automatic cls(input logic [6:0] op, input cicd_size_t sz, input cicd_class_t c,
		input logic [1:0] im);
		run(op, sz, EA_REG, 4'h0, 8'h00, im);
		chk("class", 32'(c), 32'(got.cls));
		chk("size", 32'(sz), 32'(got.size));
		chk("fault", 0, 32'(got.fault));
		chk("imm_bits", 32'(im) * 8 + 8, 32'(got.imm_bits));
		chk("fetch_addr", 32'h1234, 32'(got.fetch_addr));
	endtask

	initial begin
		rst_n = 1'b0;
		ins_valid = 1'b0;
		dec_ready = 1'b0;
		slow = 1'b0;
		ins = '0;
		cyc = 0;
		sp_value = 32'h100;
		rf = '{32'hA1B2_C3D4, 32'h1357_9BDF, 32'h0F1E_2D3C, 0, 0, 0, 0, 0};
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		chk("ins_ready", 1, ins_ready);
		chk("mem_req", 0, mem_req);
		run(OP_STK_ST_MULTI, SZ_LONG, EA_STK_PUSH, 4'h0, 8'h03, 2'h0);
		chk("st_addr0", 32'hFC, 32'(log_a[0]));
		chk("st_addr1", 32'hF8, 32'(log_a[1]));
		chk("sp", 32'hF8, sp_value);
		rf[0] = 0;
		rf[1] = 0;
		slow = 1'b1;
		run(OP_STK_LD_MULTI, SZ_LONG, EA_STK_POP, 4'h0, 8'h03, 2'h0);
		chk("ld_addr0", 32'hF8, 32'(log_a[0]));
		chk("reg0", 32'hA1B2_C3D4, rf[0]);
		chk("reg1", 32'h1357_9BDF, rf[1]);
		chk("sp", 32'h100, sp_value);
		slow = 1'b0;
		run(OP_GEN_XFER, SZ_LONG, EA_STK_PUSH, 4'h2, 8'h00, 2'h0);
		chk("push_addr", 32'hFC, 32'(log_a[0]));
		chk("sp", 32'hFC, sp_value);
		run(OP_GEN_XFER, SZ_LONG, EA_STK_POP, 4'h3, 8'h00, 2'h0);
		chk("pop_reg", 32'h0F1E_2D3C, rf[3]);
		chk("sp", 32'h100, sp_value);
		run(OP_GEN_XFER, SZ_WORD, EA_STK_PUSH, 4'h8, 8'h00, 2'h0);
		chk("push_w_addr", 32'hFE, 32'(log_a[0]));
		chk("sp", 32'hFE, sp_value);
		run(OP_GEN_XFER, SZ_WORD, EA_STK_POP, 4'h1, 8'h00, 2'h0);
		chk("pop_w_reg", 32'h1357_A1B2, rf[1]);
		chk("sp", 32'h100, sp_value);
		flt(7'h41, SZ_BYTE, EA_REG, 8'h00, 4'h0, 0);
		flt(OP_ADD_CARRY, SZ_WORD, EA_REG, 8'h00, 4'h0, 1);
		flt(OP_BIT_SET, SZ_WORD, EA_REG, 8'h00, 4'h0, 1);
		flt(OP_PSYNC_RD, SZ_BYTE, EA_REG, 8'h00, 4'h0, 2);
		flt(OP_PSYNC_WR, SZ_BYTE, EA_REG, 8'h00, 4'h0, 2);
		flt(OP_STK_ST_MULTI, SZ_LONG, EA_STK_PUSH, 8'h81, 4'h0, 3);
		flt(OP_STK_LD_MULTI, SZ_LONG, EA_STK_POP, 8'h01, 4'h0, 4);
		flt(OP_STK_ST_MULTI, SZ_WORD, EA_STK_PUSH, 8'h03, 4'h0, 1);
		flt(OP_TEST_SET, SZ_BYTE, EA_REG, 8'h00, 4'h2, 5);
		flt(OP_GEN_XFER, SZ_BYTE, EA_STK_POP, 8'h00, 4'h1, 1);
		cls(OP_RORC, SZ_WORD, CL_SHIFT, 2'h0);
		cls(OP_BIT_TST, SZ_BYTE, CL_BIT, 2'h1);
		cls(OP_BR_SUB, SZ_NONE, CL_BRANCH, 2'h2);
		cls(OP_NOP, SZ_NONE, CL_SYSTEM, 2'h3);
		cls(OP_BLK_COPY, SZ_NONE, CL_BLOCK, 2'h0);
		cls(OP_QSUB_CONST, SZ_LONG, CL_ARITH, 2'h1);
		cls(OP_XOR, SZ_BYTE, CL_LOGIC, 2'h2);
		cls(OP_GEN_XFER, SZ_BYTE, CL_TRANSFER, 2'h3);
		test_done;
	end
endmodule // cpu_instruction_class_decoder_tb

`default_nettype wire
